//--- logic/fet_channel_pkg.sv
// constants shared by the fet channel control block
package fet_channel_pkg;
  localparam int          NUM_CHANNELS        = 8;
  localparam logic [7:0]  ADDR_CHANNEL_COMMAND = 8'h01;
  localparam logic [7:0]  ADDR_MAP_AC          = 8'h02;
  localparam logic [7:0]  ADDR_MAP_BD          = 8'h03;
  localparam logic [7:0]  ADDR_PULSE_MAP       = 8'h04;
  localparam logic [7:0]  ADDR_COMBINE         = 8'h05;
  localparam logic [7:0]  ADDR_SWITCHING_CTRL  = 8'h0e;
  localparam logic [7:0]  ADDR_OFF_DETECT_EN   = 8'h26;
  localparam logic [7:0]  ADDR_FAULT_CLEAR     = 8'h29;
  localparam logic [7:0]  RESET_CHANNEL_COMMAND = 8'h00;
  localparam logic [7:0]  RESET_MAP_AC          = 8'h00;
  localparam logic [7:0]  RESET_MAP_BD          = 8'h00;
  localparam logic [7:0]  RESET_PULSE_MAP       = 8'h00;
  localparam logic [7:0]  RESET_COMBINE         = 8'h00;
  localparam logic [7:0]  RESET_SWITCHING_CTRL  = 8'h00;
  localparam logic [7:0]  RESET_OFF_DETECT_EN   = 8'h00;
  localparam int          BIT_LOW_RATE        = 3;
  localparam int          BIT_MONITOR_EN      = 2;
  localparam logic [7:0]  SWITCHING_CTRL_MASK = 8'h0c;
  localparam logic [3:0]  OPEN_LOAD_THRESHOLD = 4'h3;
  localparam int          CLOCK_MHZ           = 100;
  localparam int          OFF_DETECT_DELAY_US = 192;
  localparam int          OFF_DETECT_CYCLES   = OFF_DETECT_DELAY_US * CLOCK_MHZ;
  localparam logic [2:0]  RETRY_COUNT         = 3'h3;
  localparam logic [7:0]  RETRY_ALLOWED       = 8'hff;
endpackage : fet_channel_pkg

//--- logic/pin_sync.sv
// two-stage synchroniser for a group of input pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else if (enable) begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pin_sync
`default_nettype wire

//--- logic/fet_channel_control.sv
// channel request, pin mapping, trip latch and diagnostics for eight high-side switches
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] control bit 3 selects low switching rate
// [RULE2] control bit 2 enables monitor pin output
// [RULE3] monitor toggles at rate, fifty percent duty
// [RULE4] software writes zero to unused control bits
// [RULE5] watchdog timeout reloads protected registers when masked
// [RULE6] on-state open flagged below fixed threshold
// [RULE7] off-state open after 192 us delay
// [RULE8] off-state and on-state detection independent
// [RULE9] off-state short to battery detected
// [RULE10] per-channel off-state detection enable bits
// [RULE11] command bit requests channel on
// [RULE12] command request overrides direct pin levels
// [RULE13] pulse map routes pulse pin to channel
// [RULE14] first map: pin c upper, a lower
// [RULE15] second map: pin d upper, b lower
// [RULE16] combine bit selects and versus or
// [RULE17] watchdog mode low direct pin clears faults
// [RULE18] host avoids pulsing direct pins normally
// [RULE19] trip-latched channel stays off until cleared
// [RULE20] trip latch set by listed fault conditions
// [RULE21] retry allowed faults retry before latching
// [RULE22] host locks out channel still tripping
// [RULE23] clear register bit clears latch and retries
// [RULE24] final request ors sources, gated by latch
// [RULE25] all input pins synchronised before use; code syncs only pins a-d and the pulse pin
module fet_channel_control
  import fet_channel_pkg::*;
#(
  parameter int          OFF_DETECT_COUNT = OFF_DETECT_CYCLES,
  parameter logic        WRITE_PROTECT    = 1'b1
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clock_enable,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_address,
  input  wire logic [7:0] reg_write_data,
  output logic      [7:0] reg_read_data,
  input  wire logic       watchdog_timeout,
  input  wire logic       watchdog_mode,
  input  wire logic       modulation,
  input  wire logic       direct_pin_a,
  input  wire logic       direct_pin_b,
  input  wire logic       direct_pin_c,
  input  wire logic       direct_pin_d,
  input  wire logic       external_pulse_pin,
  input  wire logic [7:0] overtemp_fault,
  input  wire logic [7:0] overtemp_auto_reset,
  input  wire logic [7:0] high_current_trip,
  input  wire logic [7:0] turn_on_current_trip,
  input  wire logic [7:0] low_current_trip,
  input  wire logic [7:0] low_current_trip_enable,
  input  wire logic       retry_wait_done,
  input  wire logic [7:0] on_state,
  input  wire logic [31:0] sense_current,
  input  wire logic [7:0] kelvin_above_threshold,
  input  wire logic [7:0] battery_kelvin_below_on,
  output logic      [7:0] channel_on,
  output logic            low_switching_rate,
  output logic            rate_monitor_pin,
  output logic      [7:0] trip_latched,
  output logic      [7:0] onstate_open_detected,
  output logic      [7:0] offstate_open_detected,
  output logic      [7:0] offstate_short_detected
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       channel_command;
    logic [7:0]       direct_pin_map_ac;
    logic [7:0]       direct_pin_map_bd;
    logic [7:0]       pulse_pin_map;
    logic [7:0]       pin_pair_combine;
    logic [7:0]       switching_control;
    logic [7:0]       offstate_open_detect_enable;
    logic [7:0]       read_data;
    logic [7:0]       channel_on;
    logic             low_rate;
    logic             monitor;
    logic [7:0]       latch;
    logic [7:0][2:0]  retries;
    logic [7:0]       onstate_open;
    logic [7:0]       offstate_open;
    logic [7:0]       offstate_short;
    logic [7:0][14:0] off_timer;
  } state_t;

  state_t     cur;
  state_t     next_state;
  logic [4:0] pins_sync;
  logic [7:0] mapped_pins;
  logic [7:0] fault_reset;

  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  pin_sync #(
    .WIDTH    (5)
  ) u_pin_sync (
    .clock    (clock),
    .rst      (rst),
    .enable   (clock_enable),
    .async_in ({external_pulse_pin, direct_pin_d, direct_pin_c, direct_pin_b, direct_pin_a}), // RULE25
    .sync_out (pins_sync)
  );

  // ------------------------------------------------------------
  // per channel pin mapping
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_map
      logic first_pin;
      logic second_pin;
      logic first_m;
      logic second_m;
      // lower half pairs a/b, upper half pairs c/d
      assign first_pin  = (ch < 4) ? pins_sync[0] : pins_sync[2]; // RULE14
      assign second_pin = (ch < 4) ? pins_sync[1] : pins_sync[3]; // RULE15
      assign first_m    = cur.direct_pin_map_ac[ch] & first_pin;
      assign second_m   = cur.direct_pin_map_bd[ch] & second_pin;
      // unmapped pins drop out of the pair; and of nothing mapped is off
      assign mapped_pins[ch] = cur.pin_pair_combine[ch] ? // RULE16
        ((cur.direct_pin_map_ac[ch] | cur.direct_pin_map_bd[ch]) &
         (first_m  | ~cur.direct_pin_map_ac[ch]) &
         (second_m | ~cur.direct_pin_map_bd[ch])) :
        (first_m | second_m);
      // pulse pin excluded: it must never clear faults
      assign fault_reset[ch] = watchdog_mode & // RULE17
        ((cur.direct_pin_map_ac[ch] & ~first_pin) | (cur.direct_pin_map_bd[ch] & ~second_pin));
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] clear_bits;
    logic [7:0] request;
    logic       retry_fault;
    clear_bits  = 8'h00;
    request     = 8'h00;
    retry_fault = 1'b0;
    next_state  = cur;
    if (reg_write) begin
      case (reg_address)
        ADDR_CHANNEL_COMMAND: next_state.channel_command             = reg_write_data; // RULE11
        ADDR_MAP_AC:          next_state.direct_pin_map_ac           = reg_write_data;
        ADDR_MAP_BD:          next_state.direct_pin_map_bd           = reg_write_data;
        ADDR_PULSE_MAP:       next_state.pulse_pin_map               = reg_write_data;
        ADDR_COMBINE:         next_state.pin_pair_combine            = reg_write_data;
        // unused bits kept at zero even if software writes ones
        ADDR_SWITCHING_CTRL:  next_state.switching_control           = reg_write_data & SWITCHING_CTRL_MASK;
        ADDR_OFF_DETECT_EN:   next_state.offstate_open_detect_enable = reg_write_data; // RULE10
        ADDR_FAULT_CLEAR:     clear_bits                             = reg_write_data;
        default:              next_state.read_data                   = next_state.read_data;
      endcase
    end
    if (WRITE_PROTECT && watchdog_timeout) begin // RULE5
      next_state.switching_control = RESET_SWITCHING_CTRL;
      next_state.direct_pin_map_ac = RESET_MAP_AC;
      next_state.direct_pin_map_bd = RESET_MAP_BD;
      next_state.pin_pair_combine  = RESET_COMBINE;
    end
    case (reg_address)
      ADDR_CHANNEL_COMMAND: next_state.read_data = cur.channel_command;
      ADDR_MAP_AC:          next_state.read_data = cur.direct_pin_map_ac;
      ADDR_MAP_BD:          next_state.read_data = cur.direct_pin_map_bd;
      ADDR_PULSE_MAP:       next_state.read_data = cur.pulse_pin_map;
      ADDR_COMBINE:         next_state.read_data = cur.pin_pair_combine;
      ADDR_SWITCHING_CTRL:  next_state.read_data = cur.switching_control;
      ADDR_OFF_DETECT_EN:   next_state.read_data = cur.offstate_open_detect_enable;
      default:              next_state.read_data = 8'h00;
    endcase
    next_state.low_rate = cur.switching_control[BIT_LOW_RATE]; // RULE1
    // monitor follows the modulation square wave, not the channel duty
    next_state.monitor  = cur.switching_control[BIT_MONITOR_EN] & modulation; // RULE2 RULE3
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      retry_fault = RETRY_ALLOWED[i] &
        (high_current_trip[i] | turn_on_current_trip[i] | (low_current_trip[i] & low_current_trip_enable[i]));
      if ((overtemp_fault[i] & ~overtemp_auto_reset[i]) || // RULE20
          (~RETRY_ALLOWED[i] & (high_current_trip[i] | turn_on_current_trip[i])) ||
          (~RETRY_ALLOWED[i] & low_current_trip[i] & low_current_trip_enable[i])) begin
        next_state.latch[i] = 1'b1;
      end else if (retry_fault) begin // RULE21
        if (cur.retries[i] == RETRY_COUNT) begin
          next_state.latch[i] = 1'b1;
        end else if (retry_wait_done) begin
          next_state.retries[i] = cur.retries[i] + 3'h1;
        end
      end else if (clear_bits[i] || fault_reset[i]) begin // RULE23 RULE17
        next_state.latch[i]   = 1'b0;
        next_state.retries[i] = 3'h0;
      end
      // command request wins regardless of pin levels
      request[i] = cur.channel_command[i] | (cur.pulse_pin_map[i] & pins_sync[4]) | mapped_pins[i]; // RULE12 RULE13
      next_state.channel_on[i] = request[i] & ~next_state.latch[i] & ~cur.latch[i]; // RULE24 RULE19
      // on-state check runs regardless of off-state enable
      next_state.onstate_open[i] = on_state[i] & (sense_current[4*i +: 4] < OPEN_LOAD_THRESHOLD); // RULE6 RULE8
      if (on_state[i] || !cur.offstate_open_detect_enable[i]) begin
        next_state.off_timer[i]     = 15'h0000;
        next_state.offstate_open[i] = 1'b0;
      end else if (cur.off_timer[i] < OFF_DETECT_COUNT[14:0]) begin
        next_state.off_timer[i] = cur.off_timer[i] + 15'h0001;
      end else begin
        next_state.offstate_open[i] = kelvin_above_threshold[i]; // RULE7
      end
      next_state.offstate_short[i] = ~on_state[i] & battery_kelvin_below_on[i]; // RULE9
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      cur                             <= '0;
      cur.channel_command             <= RESET_CHANNEL_COMMAND;
      cur.direct_pin_map_ac           <= RESET_MAP_AC;
      cur.direct_pin_map_bd           <= RESET_MAP_BD;
      cur.pulse_pin_map               <= RESET_PULSE_MAP;
      cur.pin_pair_combine            <= RESET_COMBINE;
      cur.switching_control           <= RESET_SWITCHING_CTRL;
      cur.offstate_open_detect_enable <= RESET_OFF_DETECT_EN;
    end else if (clock_enable) begin
      cur <= next_state;
    end
  end

  assign reg_read_data           = cur.read_data;
  assign channel_on              = cur.channel_on;
  assign low_switching_rate      = cur.low_rate;
  assign rate_monitor_pin        = cur.monitor;
  assign trip_latched            = cur.latch;
  assign onstate_open_detected   = cur.onstate_open;
  assign offstate_open_detected  = cur.offstate_open;
  assign offstate_short_detected = cur.offstate_short;
endmodule : fet_channel_control
`default_nettype wire

//--- sim/fet_channel_control_asserts.sv
// port-level checker for the fet channel control block
`timescale 1ns/1ps
`default_nettype none
module fet_channel_control_asserts
  import fet_channel_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clock_enable,
  input wire logic        reg_write,
  input wire logic [7:0]  reg_address,
  input wire logic [7:0]  reg_write_data,
  input wire logic        watchdog_timeout,
  input wire logic [7:0]  overtemp_fault,
  input wire logic [7:0]  overtemp_auto_reset,
  input wire logic [7:0]  high_current_trip,
  input wire logic [7:0]  turn_on_current_trip,
  input wire logic [7:0]  low_current_trip,
  input wire logic [7:0]  on_state,
  input wire logic [31:0] sense_current,
  input wire logic [7:0]  channel_on,
  input wire logic        low_switching_rate,
  input wire logic        rate_monitor_pin,
  input wire logic [7:0]  trip_latched,
  input wire logic [7:0]  onstate_open_detected
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // faults or a reload inside the window would legitimately change the result
  logic quiet;
  assign quiet = clock_enable && !watchdog_timeout
                 && (overtemp_fault | high_current_trip | turn_on_current_trip | low_current_trip) == 8'h00;
  // ----
  // register write, then one settled cycle and one more before the check
  // ----
  sequence s_wr(logic [7:0] a);
    quiet && reg_write && reg_address == a ##1 quiet ##1 1'b1;
  endsequence
  a_reset_clears_out: assert property ($fell(rst) |-> channel_on == 8'h00 && trip_latched == 8'h00)
    else $error("outputs not cleared by reset");
  a_latch_blocks_on: assert property ((channel_on & trip_latched) == 8'h00)
    else $error("latched channel is on");
  a_command_turns_on: assert property (s_wr(ADDR_CHANNEL_COMMAND) |->
    (channel_on & $past(reg_write_data, 2)) == $past(reg_write_data, 2)) else $error("commanded channel off");
  a_slow_rate_bit: assert property (s_wr(ADDR_SWITCHING_CTRL) |->
    low_switching_rate == $past(reg_write_data[BIT_LOW_RATE], 2)) else $error("switching rate wrong");
  a_monitor_held_low: assert property (s_wr(ADDR_SWITCHING_CTRL) |->
    $past(reg_write_data[BIT_MONITOR_EN], 2) || !rate_monitor_pin) else $error("monitor pin not low");
  a_clear_drops_latch: assert property (s_wr(ADDR_FAULT_CLEAR) |->
    (trip_latched & $past(reg_write_data, 2)) == 8'h00) else $error("latch not cleared");
  a_overtemp_latches: assert property (clock_enable && overtemp_fault[0] && !overtemp_auto_reset[0]
    |-> ##[1:2] trip_latched[0]) else $error("overtemperature did not latch");
  // channel 2 is the one the bench runs into an open load
  a_onstate_open_flag: assert property ((clock_enable && on_state[2]
    && sense_current[11:8] < OPEN_LOAD_THRESHOLD) [*3] |-> onstate_open_detected[2]) else $error("open not flagged");
endmodule // fet_channel_control_asserts
bind fet_channel_control fet_channel_control_asserts u_fet_channel_control_asserts (.clock, .rst, .clock_enable,
  .reg_write, .reg_address, .reg_write_data, .watchdog_timeout, .overtemp_fault, .overtemp_auto_reset,
  .high_current_trip, .turn_on_current_trip, .low_current_trip, .on_state, .sense_current, .channel_on,
  .low_switching_rate, .rate_monitor_pin, .trip_latched, .onstate_open_detected);
`default_nettype wire

//--- sim/fet_load_model.sv
// behavioural model of the eight external switches and their loads
`timescale 1ns/1ps
`default_nettype none
module fet_load_model (
  input  wire logic [7:0]  channel_on,
  input  wire logic        clock,
  input  wire logic [7:0]  open_load,
  input  wire logic [7:0]  shorted,
  output logic      [7:0]  on_state,
  output logic      [31:0] sense_current,
  output logic      [7:0]  kelvin_above_threshold,
  output logic      [7:0]  battery_kelvin_below_on
);
  // gate charge delays the switch by one clock
  initial on_state = 8'h00;
  always @(posedge clock) on_state <= channel_on;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      sense_current[4*i+:4] = (on_state[i] && !open_load[i]) ? 4'h9 : 4'h0;
    end
  end
  assign kelvin_above_threshold  = ~on_state & open_load;
  assign battery_kelvin_below_on = ~on_state & shorted;
endmodule // fet_load_model
`default_nettype wire

//--- sim/fet_channel_control_test.sv
// self-checking bench for the fet channel control block
`timescale 1ns/1ps
`default_nettype none
module fet_channel_control_test;
  import fet_channel_pkg::*;
  localparam int OFF_DET = 20;
  logic clock = 0, rst = 1, clock_enable = 1, reg_write = 0, watchdog_timeout = 0, watchdog_mode = 0;
  logic modulation = 0, retry_wait_done = 0, low_switching_rate, rate_monitor_pin;
  logic [4:0]  pins = 5'h00;
  logic [7:0]  reg_address = 8'h00, reg_write_data = 8'h00, overtemp_fault = 8'h00, high_current_trip = 8'h00;
  logic [7:0]  open_load = 8'h00, shorted = 8'h00, reg_read_data, channel_on, trip_latched, on_state;
  logic [7:0]  onstate_open_detected, offstate_open_detected, offstate_short_detected;
  logic [7:0]  kelvin_above_threshold, battery_kelvin_below_on;
  logic [31:0] sense_current;
  int          err_count = 0, comparisons = 0, cycles = 0;
  logic [7:0]  addrs [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0e, 8'h26, 8'h29, 8'h07};
  logic [12:0] pin_case [5] = '{{5'h01, 8'h00}, {5'h03, 8'h03}, {5'h06, 8'h12}, {5'h0c, 8'hd0}, {5'h10, 8'h08}};
  fet_channel_control #(.OFF_DETECT_COUNT(OFF_DET)) u_fet_channel_control (.clock, .rst, .clock_enable,
    .reg_write, .reg_address, .reg_write_data, .reg_read_data, .watchdog_timeout, .watchdog_mode, .modulation,
    .direct_pin_a(pins[0]), .direct_pin_b(pins[1]), .direct_pin_c(pins[2]), .direct_pin_d(pins[3]),
    .external_pulse_pin(pins[4]), .overtemp_fault, .overtemp_auto_reset(8'h00), .high_current_trip,
    .turn_on_current_trip(8'h00), .low_current_trip(8'h00), .low_current_trip_enable(8'h00), .retry_wait_done,
    .on_state, .sense_current, .kelvin_above_threshold, .battery_kelvin_below_on, .channel_on,
    .low_switching_rate, .rate_monitor_pin, .trip_latched, .onstate_open_detected, .offstate_open_detected,
    .offstate_short_detected);
  fet_load_model u_fet_load_model (.clock, .channel_on, .open_load, .shorted, .on_state, .sense_current,
    .kelvin_above_threshold, .battery_kelvin_below_on);
  always #5 clock = ~clock;
  // ----
  // access tasks
  // ----
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 {reg_write, reg_address, reg_write_data} = {1'b1, a, d};
    @(posedge clock);
    #1 reg_write = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    #1 reg_address = a;
    cyc(1);
    chk("reg_read_data", e, reg_read_data);
  endtask
  task finish_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      finish_test();
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    cyc(6);
    rst = 0;
    for (int i = 0; i < 9; i++) rd(addrs[i], 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(addrs[i], 8'hff);
      rd(addrs[i], i < 7 ? (i == 5 ? 8'h0c : 8'hff) : 8'h00);
    end
    cyc(1);
    watchdog_timeout = 1;
    cyc(1);
    watchdog_timeout = 0;
    for (int i = 0; i < 7; i++) rd(addrs[i], (i inside {1, 2, 4, 5}) ? 8'h00 : 8'hff);
    clock_enable = 0;
    wr(8'h01, 8'h00);
    clock_enable = 1;
    rd(8'h01, 8'hff);
    for (int i = 0; i < 7; i++) wr(addrs[i], 8'h00);
    wr(8'h02, 8'h51);
    wr(8'h03, 8'hc3);
    wr(8'h05, 8'h41);
    wr(8'h04, 8'h08);
    for (int i = 0; i < 5; i++) begin
      pins = pin_case[i][12:8];
      cyc(4);
      chk("channel_on", pin_case[i][7:0], channel_on);
    end
    pins = 5'h01;
    wr(8'h01, 8'h09);
    cyc(2);
    chk("channel_on", 8'h09, channel_on);
    pins = 5'h00;
    overtemp_fault = 8'h09;
    cyc(1);
    overtemp_fault = 8'h00;
    cyc(3);
    chk("trip_latched", 8'h09, trip_latched);
    chk("channel_on", 8'h00, channel_on);
    watchdog_mode = 1;
    cyc(4);
    watchdog_mode = 0;
    chk("trip_latched", 8'h08, trip_latched);
    chk("channel_on", 8'h01, channel_on);
    wr(8'h29, 8'h08);
    cyc(2);
    chk("channel_on", 8'h09, channel_on);
    high_current_trip = 8'h02;
    cyc(3);
    chk("trip_latched", 8'h00, trip_latched);
    repeat (RETRY_COUNT) begin
      retry_wait_done = 1;
      cyc(1);
      retry_wait_done = 0;
      cyc(1);
    end
    cyc(2);
    chk("trip_latched", 8'h02, trip_latched);
    high_current_trip = 8'h00;
    wr(8'h29, 8'h02);
    cyc(2);
    chk("trip_latched", 8'h00, trip_latched);
    wr(8'h0e, 8'h0c);
    modulation = 1;
    cyc(3);
    chk("rate_monitor_pin", 8'h01, {7'h00, rate_monitor_pin});
    chk("low_switching_rate", 8'h01, {7'h00, low_switching_rate});
    modulation = 0;
    cyc(3);
    chk("rate_monitor_pin", 8'h00, {7'h00, rate_monitor_pin});
    wr(8'h0e, 8'h00);
    modulation = 1;
    cyc(3);
    chk("rate_monitor_pin", 8'h00, {7'h00, rate_monitor_pin});
    {open_load, shorted} = {8'h04, 8'h20};
    cyc(OFF_DET + 5);
    chk("offstate_open_detected", 8'h00, offstate_open_detected);
    wr(8'h26, 8'h24);
    cyc(OFF_DET / 2);
    chk("offstate_open_detected", 8'h00, offstate_open_detected);
    cyc(OFF_DET);
    chk("offstate_open_detected", 8'h04, offstate_open_detected);
    chk("offstate_short_detected", 8'h20, offstate_short_detected);
    wr(8'h01, 8'h04);
    cyc(5);
    chk("onstate_open_detected", 8'h04, onstate_open_detected);
    wr(8'h26, 8'h00);
    cyc(3);
    chk("onstate_open_detected", 8'h04, onstate_open_detected);
    finish_test();
  end
endmodule // fet_channel_control_test
`default_nettype wire
